// file: src/dl2_irq_ctrl.sv
`timescale 1ns/1ps
`include "dl2_irq_regs.svh"
// Summary of operation
// RULE1 - With the transmit begin enable set, a transmit start raises the interrupt.
// RULE2 - With the receive begin enable set, a receive start raises the interrupt.
// RULE3 - With the transmit done enable set, a finished transmission raises the interrupt.
// RULE4 - With the receive done enable set, a complete received message raises the interrupt.
// RULE5 - With the checksum enable set, a frame check error raises the interrupt.
// RULE6 - With the abort enable set, seven ones in a row on the link raise the interrupt.
// RULE7 - With the flag enable set, a received flag octet raises the interrupt.
// RULE8 - Event enables are read/write, reset to zero, and gate their interrupt.
// RULE9 - A received message longer than 276 bytes is flagged as oversize.
// RULE10 - The oversize status bit resets to zero, sets on the event and clears on read.
// RULE11 - The oversize enable bit resets to zero and gates the oversize interrupt.
// RULE12 - Each link event status bit sets on its event and clears when read.
// RULE13 - A full receive buffer also declares the receive done event.
// RULE14 - The request is high while any status bit and its enable are both set.
module dl2_irq_ctrl (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Events from the data link controllers, one-cycle pulses.
  input wire dl2_irq_pkg::dl_events_t events,
  input wire dl2_irq_pkg::rx_feed_t rx_feed,
  // Interrupt outputs.
  output logic irq_req,
  output logic irq
);
  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic access, wr, rd;
  logic [`IDX_W-1:0] idx;
  logic mapped;
  assign access = psel && penable && pready;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;
  assign idx = paddr[`IDX_W+1:2];
  always_comb begin
    case (idx)
      `IDX_DL2_STATUS, `IDX_DL2_ENABLES, `IDX_OVS_STATUS, `IDX_OVS_ENABLE,
      `IDX_IRQ_STATUS, `IDX_IRQ_ENABLE, `IDX_IRQ_CLEAR: mapped = (paddr[1:0] == 2'h0);
      default: mapped = 1'b0;
    endcase
  end

  // ****************************************************************
  // Oversize detection
  // ****************************************************************
  logic ovs_pulse;
  logic rx_done_ev;
  oversize_counter #(.CNT_W(16)) u_ovs (
    .pclk(pclk),
    .presetn(presetn),
    .rx_begin(events.rx_begin),
    .rx_byte(rx_feed.rx_byte),
    .rx_end(rx_feed.rx_msg_end),
    .oversize_pulse(ovs_pulse)
  );
  assign rx_done_ev = events.rx_done || rx_feed.rx_buf_full; // RULE13

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [`DL_EVENTS-1:0] dl_stat_q, dl_stat_d, dl_en_q, dl_en_d, ev_vec;
  logic ovs_stat_q, ovs_stat_d, ovs_en_q, ovs_en_d;
  logic [`CAUSE_W-1:0] cause_q, cause_d, cause_en_q, cause_en_d, cause_raw;
  logic [31:0] rdata_d;
  logic pready_d, pslverr_d, irq_req_d, irq_d;
  always_comb begin
    ev_vec = '0;
    ev_vec[`BIT_TX_BEGIN] = events.tx_begin; // RULE1
    ev_vec[`BIT_RX_BEGIN] = events.rx_begin; // RULE2
    ev_vec[`BIT_TX_DONE] = events.tx_done; // RULE3
    ev_vec[`BIT_RX_DONE] = rx_done_ev; // RULE4
    ev_vec[`BIT_CHECKSUM] = events.checksum_fault; // RULE5
    ev_vec[`BIT_ABORT] = events.abort_seen; // RULE6
    ev_vec[`BIT_FLAG] = events.flag_seen; // RULE7
  end
  always_comb begin
    dl_stat_d = dl_stat_q;
    dl_en_d = dl_en_q;
    ovs_stat_d = ovs_stat_q;
    ovs_en_d = ovs_en_q;
    cause_en_d = cause_en_q;
    cause_d = cause_q;
    rdata_d = 32'h0000_0000;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    // Single wait state: pready rises in the second access cycle.
    if (psel && penable && !pready) begin
      pready_d = 1'b1;
      pslverr_d = !mapped;
      case (idx)
        `IDX_DL2_STATUS: rdata_d[`DL_EVENTS-1:0] = dl_stat_q;
        `IDX_DL2_ENABLES: rdata_d[`DL_EVENTS-1:0] = dl_en_q;
        `IDX_OVS_STATUS: rdata_d[`BIT_OVERSIZE] = ovs_stat_q;
        `IDX_OVS_ENABLE: rdata_d[`BIT_OVERSIZE] = ovs_en_q;
        `IDX_IRQ_STATUS: rdata_d[`CAUSE_W-1:0] = cause_q;
        `IDX_IRQ_ENABLE: rdata_d[`CAUSE_W-1:0] = cause_en_q;
        default: rdata_d = 32'h0000_0000;
      endcase
      if (pwrite || !mapped) begin
        rdata_d = 32'h0000_0000;
      end
    end
    // Read-to-clear; a same-cycle event wins over the clear.
    if (rd && idx == `IDX_DL2_STATUS && mapped) begin
      dl_stat_d = '0; // RULE12
    end
    if (rd && idx == `IDX_OVS_STATUS && mapped) begin
      ovs_stat_d = 1'b0; // RULE10
    end
    if (wr && mapped) begin
      case (idx)
        `IDX_DL2_ENABLES: dl_en_d = pwdata[`DL_EVENTS-1:0]; // RULE8
        `IDX_OVS_ENABLE: ovs_en_d = pwdata[`BIT_OVERSIZE]; // RULE11
        `IDX_IRQ_ENABLE: cause_en_d = pwdata[`CAUSE_W-1:0];
        `IDX_IRQ_CLEAR: cause_d = cause_q & ~pwdata[`CAUSE_W-1:0];
        default: cause_d = cause_d;
      endcase
    end
    dl_stat_d = dl_stat_d | ev_vec; // RULE12
    ovs_stat_d = ovs_stat_d | ovs_pulse; // RULE10
    cause_raw = '0;
    cause_raw[`CAUSE_DL] = |(dl_stat_d & dl_en_d); // RULE8
    cause_raw[`CAUSE_OVS] = ovs_stat_d & ovs_en_d; // RULE11
    irq_req_d = |cause_raw; // RULE14
    cause_d = cause_d | (ev_vec != '0 ? {1'b0, |(ev_vec & dl_en_q)} : '0)
      | {ovs_pulse & ovs_en_q, 1'b0};
    irq_d = |(cause_d & cause_en_d);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dl_stat_q <= '0;
      dl_en_q <= '0;
      ovs_stat_q <= 1'b0;
      ovs_en_q <= 1'b0;
      cause_q <= '0;
      cause_en_q <= '0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq_req <= 1'b0;
      irq <= 1'b0;
    end else begin
      dl_stat_q <= dl_stat_d;
      dl_en_q <= dl_en_d;
      ovs_stat_q <= ovs_stat_d;
      ovs_en_q <= ovs_en_d;
      cause_q <= cause_d;
      cause_en_q <= cause_en_d;
      prdata <= rdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
      irq_req <= irq_req_d;
      irq <= irq_d;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_tx_begin;
    @(posedge pclk) disable iff (!presetn)
      (events.tx_begin && dl_en_q[`BIT_TX_BEGIN]) |=> irq_req;
  endproperty
  a_tx_begin: assert property (p_tx_begin) else $error("tx begin no request"); // RULE1
  property p_rx_begin;
    @(posedge pclk) disable iff (!presetn)
      (events.rx_begin && dl_en_q[`BIT_RX_BEGIN]) |=> dl_stat_q[`BIT_RX_BEGIN] && irq_req;
  endproperty
  a_rx_begin: assert property (p_rx_begin) else $error("rx begin no request"); // RULE2
  property p_tx_done;
    @(posedge pclk) disable iff (!presetn)
      events.tx_done |=> dl_stat_q[`BIT_TX_DONE];
  endproperty
  a_tx_done: assert property (p_tx_done) else $error("tx done not latched"); // RULE3
  property p_rx_done;
    @(posedge pclk) disable iff (!presetn)
      rx_feed.rx_buf_full |=> dl_stat_q[`BIT_RX_DONE];
  endproperty
  a_rx_done: assert property (p_rx_done) else $error("buffer full not latched"); // RULE13
  property p_checksum;
    @(posedge pclk) disable iff (!presetn)
      events.checksum_fault |=> dl_stat_q[`BIT_CHECKSUM];
  endproperty
  a_checksum: assert property (p_checksum) else $error("checksum not latched"); // RULE5
  property p_masked;
    @(posedge pclk) disable iff (!presetn)
      (dl_en_q == '0 && !ovs_en_q && !wr) |=> !irq_req;
  endproperty
  a_masked: assert property (p_masked) else $error("request while masked"); // RULE8
  property p_read_clear;
    @(posedge pclk) disable iff (!presetn)
      (rd && mapped && idx == `IDX_OVS_STATUS && !ovs_pulse) |=> !ovs_stat_q;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("oversize not cleared"); // RULE10
  property p_request;
    @(posedge pclk) disable iff (!presetn)
      irq_req == (|(dl_stat_q & dl_en_q) || (ovs_stat_q && ovs_en_q));
  endproperty
  a_request: assert property (p_request) else $error("request mismatch"); // RULE14
  property p_pready;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable) ##1 (psel && penable) |=> pready;
  endproperty
  a_pready: assert property (p_pready) else $error("pready late");

  // ****************************************************************
  // Event, register and output checks
  // ****************************************************************
  property p_tx_begin_set;
    @(posedge pclk) disable iff (!presetn)
      events.tx_begin |=> dl_stat_q[`BIT_TX_BEGIN];
  endproperty
  a_tx_begin_set: assert property (p_tx_begin_set) else $error("tx begin not latched"); // RULE1
  property p_tx_done_irq;
    @(posedge pclk) disable iff (!presetn)
      (events.tx_done && dl_en_q[`BIT_TX_DONE] && !wr) |=> irq_req;
  endproperty
  a_tx_done_irq: assert property (p_tx_done_irq) else $error("tx done no request"); // RULE3
  property p_rx_end;
    @(posedge pclk) disable iff (!presetn)
      events.rx_done |=> dl_stat_q[`BIT_RX_DONE];
  endproperty
  a_rx_end: assert property (p_rx_end) else $error("rx done not latched"); // RULE4
  property p_checksum_irq;
    @(posedge pclk) disable iff (!presetn)
      (events.checksum_fault && dl_en_q[`BIT_CHECKSUM] && !wr) |=> irq_req;
  endproperty
  a_checksum_irq: assert property (p_checksum_irq) else $error("checksum no request"); // RULE5
  property p_abort;
    @(posedge pclk) disable iff (!presetn)
      events.abort_seen |=> dl_stat_q[`BIT_ABORT];
  endproperty
  a_abort: assert property (p_abort) else $error("abort not latched"); // RULE6
  property p_flag;
    @(posedge pclk) disable iff (!presetn)
      events.flag_seen |=> dl_stat_q[`BIT_FLAG];
  endproperty
  a_flag: assert property (p_flag) else $error("flag not latched"); // RULE7
  property p_en_hold;
    @(posedge pclk) disable iff (!presetn)
      !(wr && mapped && idx == `IDX_DL2_ENABLES) |=> $stable(dl_en_q);
  endproperty
  a_en_hold: assert property (p_en_hold) else $error("enables changed"); // RULE8
  property p_en_write;
    @(posedge pclk) disable iff (!presetn)
      (wr && mapped && idx == `IDX_DL2_ENABLES) |=> dl_en_q == `DL_EVENTS'($past(pwdata));
  endproperty
  a_en_write: assert property (p_en_write) else $error("enables not written"); // RULE8
  property p_en_readback;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready && !pwrite && idx == `IDX_DL2_ENABLES && mapped)
      |=> prdata[`DL_EVENTS-1:0] == $past(dl_en_q);
  endproperty
  a_en_readback: assert property (p_en_readback) else $error("enables misread"); // RULE8
  property p_ovs_set;
    @(posedge pclk) disable iff (!presetn)
      ovs_pulse |=> ovs_stat_q;
  endproperty
  a_ovs_set: assert property (p_ovs_set) else $error("oversize not latched"); // RULE10
  property p_ovs_irq;
    @(posedge pclk) disable iff (!presetn)
      (ovs_pulse && ovs_en_q && !wr) |=> irq_req;
  endproperty
  a_ovs_irq: assert property (p_ovs_irq) else $error("oversize no request"); // RULE11
  property p_dl_read_clear;
    @(posedge pclk) disable iff (!presetn)
      (rd && mapped && idx == `IDX_DL2_STATUS && ev_vec == '0) |=> dl_stat_q == '0;
  endproperty
  a_dl_read_clear: assert property (p_dl_read_clear) else $error("not cleared"); // RULE12
  property p_status_ro;
    @(posedge pclk) disable iff (!presetn)
      (wr && idx == `IDX_DL2_STATUS && ev_vec == '0) |=> $stable(dl_stat_q);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status written"); // RULE12
  property p_pready_pulse;
    @(posedge pclk) disable iff (!presetn)
      pready |=> !pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse) else $error("pready stuck");
  property p_slverr_ready;
    @(posedge pclk) disable iff (!presetn)
      pslverr |-> pready;
  endproperty
  a_slverr_ready: assert property (p_slverr_ready) else $error("pslverr alone");
  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
      irq == |(cause_q & cause_en_q);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq mismatch");
  property p_cause_set;
    @(posedge pclk) disable iff (!presetn)
      (events.flag_seen && dl_en_q[`BIT_FLAG]) |=> cause_q[`CAUSE_DL];
  endproperty
  a_cause_set: assert property (p_cause_set) else $error("cause not set");
endmodule // dl2_irq_ctrl

// file: src/dl2_irq_pkg.sv
package dl2_irq_pkg;
  typedef struct packed {
    logic tx_begin;
    logic rx_begin;
    logic tx_done;
    logic rx_done;
    logic checksum_fault;
    logic abort_seen;
    logic flag_seen;
  } dl_events_t;
  typedef struct packed {
    logic rx_byte;
    logic rx_msg_end;
    logic rx_buf_full;
  } rx_feed_t;
endpackage

// file: src/dl2_irq_regs.svh
`ifndef DL2_IRQ_REGS_SVH
`define DL2_IRQ_REGS_SVH
// Register indices (printed offsets are not all multiples of four).
`define IDX_DL2_STATUS 12'hb18
`define IDX_DL2_ENABLES 12'hb1a
`define IDX_OVS_STATUS 12'hb19
`define IDX_OVS_ENABLE 12'hb1b
`define IDX_IRQ_STATUS 12'hb1c
`define IDX_IRQ_ENABLE 12'hb1d
`define IDX_IRQ_CLEAR 12'hb1e
`define IDX_W 12
// Bit positions of the enable and status layouts.
`define BIT_TX_BEGIN 6
`define BIT_RX_BEGIN 5
`define BIT_TX_DONE 4
`define BIT_RX_DONE 3
`define BIT_CHECKSUM 2
`define BIT_ABORT 1
`define BIT_FLAG 0
`define BIT_OVERSIZE 0
`define DL_EVENTS 7
`define RST_BYTE 8'h00
`define OVERSIZE_LIMIT 16'h0114
`define CAUSE_DL 0
`define CAUSE_OVS 1
`define CAUSE_W 2
`endif

// file: src/oversize_counter.sv
`timescale 1ns/1ps
`include "dl2_irq_regs.svh"
module oversize_counter #(
  parameter int CNT_W = 16
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Received byte stream markers.
  input wire logic rx_begin,
  input wire logic rx_byte,
  input wire logic rx_end,
  // One-cycle oversize pulse.
  output logic oversize_pulse
);
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic fired_q, fired_d;
  logic pulse_d;
  always_comb begin
    cnt_d = cnt_q;
    fired_d = fired_q;
    pulse_d = 1'b0;
    if (rx_begin || rx_end) begin
      cnt_d = '0;
      fired_d = 1'b0;
    end else if (rx_byte && !fired_q) begin
      cnt_d = cnt_q + 1'b1;
      // Only the first byte past the limit reports, once per message.
      if (cnt_q == CNT_W'(`OVERSIZE_LIMIT)) begin // RULE9
        pulse_d = 1'b1;
        fired_d = 1'b1;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      fired_q <= 1'b0;
      oversize_pulse <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      fired_q <= fired_d;
      oversize_pulse <= pulse_d;
    end
  end
endmodule // oversize_counter

// file: tb/dl2_irq_ctrl_tb.sv
`timescale 1ns/1ps
`include "dl2_irq_regs.svh"
module dl2_irq_ctrl_tb;
  // ****************************************
  // Design under test and clock.
  // ****************************************
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_req, irq, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  dl2_irq_pkg::dl_events_t events;
  dl2_irq_pkg::rx_feed_t rx_feed;
  int n_errors = 0;
  int total_checks = 0;
  dl2_irq_ctrl dl2_irq_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .events(events), .rx_feed(rx_feed), .irq_req(irq_req), .irq(irq)
  );
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // ****************************************
  // Tasks.
  // ****************************************
  task automatic report_and_stop();
    if (n_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One APB transfer; entered and left just after a rising edge.
  task automatic xfer(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {18'h00000, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      n_errors++;
      report_and_stop();
    end
    @(posedge pclk);
  endtask
  task automatic rdchk(input string name, input logic [11:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h00000000);
    chk(name, rd, exp);
  endtask
  task automatic pulse(input logic [6:0] e, input logic [2:0] f);
    events <= dl2_irq_pkg::dl_events_t'(e);
    rx_feed <= dl2_irq_pkg::rx_feed_t'(f);
    @(posedge pclk);
    events <= '0;
    rx_feed <= '0;
    @(posedge pclk);
  endtask
  task automatic look(input logic exp_req, input logic exp_irq);
    @(negedge pclk);
    chk("irq_req", {31'h0, irq_req}, {31'h0, exp_req});
    chk("irq", {31'h0, irq}, {31'h0, exp_irq});
    @(posedge pclk);
  endtask
  // ****************************************
  // Main sequence.
  // ****************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h00000000;
    pwdata = 32'h00000000;
    events = '0;
    rx_feed = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk("enables", `IDX_DL2_ENABLES, 32'h00000000);
    rdchk("ovs_enable", `IDX_OVS_ENABLE, 32'h00000000);
    rdchk("ovs_status", `IDX_OVS_STATUS, 32'h00000000);
    rdchk("dl_status", `IDX_DL2_STATUS, 32'h00000000);
    xfer(1'b0, 12'h0a0, 32'h00000000);
    chk("unmapped_err", {31'h0, err}, 32'h00000001);
    xfer(1'b1, `IDX_DL2_ENABLES, 32'h000000ff);
    rdchk("enables", `IDX_DL2_ENABLES, 32'h0000007f);
    for (int i = 0; i < 7; i++) begin
      pulse(7'h01 << i, 3'h0);
      look(1'b1, 1'b0);
      rdchk("dl_status", `IDX_DL2_STATUS, 32'h00000001 << i);
      look(1'b0, 1'b0);
    end
    pulse(7'h00, 3'h1);
    look(1'b1, 1'b0);
    rdchk("dl_status", `IDX_DL2_STATUS, 32'h00000008);
    xfer(1'b1, `IDX_DL2_ENABLES, 32'h00000000);
    pulse(7'h7f, 3'h0);
    look(1'b0, 1'b0);
    xfer(1'b1, `IDX_DL2_STATUS, 32'h00000000);
    rdchk("dl_status", `IDX_DL2_STATUS, 32'h0000007f);
    rdchk("dl_status", `IDX_DL2_STATUS, 32'h00000000);
    xfer(1'b1, `IDX_OVS_ENABLE, 32'h00000001);
    rdchk("ovs_enable", `IDX_OVS_ENABLE, 32'h00000001);
    pulse(7'h20, 3'h2);
    for (int i = 0; i < 276; i++) pulse(7'h00, 3'h4);
    look(1'b0, 1'b0);
    pulse(7'h00, 3'h4);
    look(1'b1, 1'b0);
    rdchk("ovs_status", `IDX_OVS_STATUS, 32'h00000001);
    rdchk("ovs_status", `IDX_OVS_STATUS, 32'h00000000);
    look(1'b0, 1'b0);
    xfer(1'b1, `IDX_OVS_ENABLE, 32'h00000000);
    pulse(7'h20, 3'h2);
    repeat (277) pulse(7'h00, 3'h4);
    look(1'b0, 1'b0);
    rdchk("ovs_status", `IDX_OVS_STATUS, 32'h00000001);
    rdchk("dl_status", `IDX_DL2_STATUS, 32'h00000020);
    xfer(1'b1, `IDX_IRQ_CLEAR, 32'h00000003);
    xfer(1'b1, `IDX_IRQ_ENABLE, 32'h00000003);
    xfer(1'b1, `IDX_DL2_ENABLES, 32'h00000001);
    look(1'b0, 1'b0);
    pulse(7'h01, 3'h0);
    look(1'b1, 1'b1);
    rdchk("irq_status", `IDX_IRQ_STATUS, 32'h00000001);
    xfer(1'b1, `IDX_IRQ_ENABLE, 32'h00000000);
    look(1'b1, 1'b0);
    xfer(1'b1, `IDX_IRQ_CLEAR, 32'h00000001);
    xfer(1'b1, `IDX_IRQ_ENABLE, 32'h00000003);
    look(1'b1, 1'b0);
    rdchk("irq_status", `IDX_IRQ_STATUS, 32'h00000000);
    report_and_stop();
  end
endmodule // dl2_irq_ctrl_tb
